// >>> src/scd_regs.vh
`ifndef SCD_REGS_VH
`define SCD_REGS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define SCD_ADDR_W 8
`define SCD_DATA_W 8
`define SCD_CTRL_ADDR 8'hbd
`define SCD_CTRL_RESET 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCD_READY_BIT 7
`define SCD_DIV_MSB 6
`define SCD_DIV_LSB 4
`define SCD_RSVD_BIT 3
`define SCD_SRC_MSB 2
`define SCD_SRC_LSB 0
`define SCD_DIV_W 3
`define SCD_SRC_W 3

// ----------------------------------------
// field codes and divider sizing
// ----------------------------------------
`define SCD_SRC_INT 3'h0
`define SCD_SRC_EXT 3'h1
`define SCD_DIV_RESET 3'h0
`define SCD_SRC_RESET 3'h0
`define SCD_CNT_W 7

`endif

// >>> src/scd_edge.v
`timescale 1ns/1ps
`default_nettype none

module scd_edge
(
  input wire core_clk,
  input wire resetn,
  input wire level_in,
  output wire rise
);

  reg level_reg;

  // inputs are synchronous to core_clk, so one stage suffices
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_reg <= 1'b0;
    end
    else
    begin
      level_reg <= level_in;
    end
  end

  assign rise = level_in & ~level_reg;

endmodule

`default_nettype wire

// >>> src/scd_clock_ctrl.v
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "scd_regs.vh"

module scd_clock_ctrl
#(
  parameter CNT_W = `SCD_CNT_W
)
(
  input wire core_clk,
  input wire resetn,
  input wire [`SCD_ADDR_W-1:0] reg_addr,
  input wire [`SCD_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`SCD_DATA_W-1:0] reg_rdata,
  input wire int_osc_in,
  input wire ext_osc_in,
  output reg core_clock_out,
  output wire divider_ready_flag
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [1:0] ST_PEND = 2'b01;
  localparam [1:0] ST_READY = 2'b10;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // written values, readable at once
  reg [`SCD_DIV_W-1:0] core_clock_out_divide_field_reg;
  reg [`SCD_SRC_W-1:0] clock_source_select_field_reg;
  // values in effect on the output clock
  reg [`SCD_DIV_W-1:0] act_div_reg;
  reg [`SCD_DIV_W-1:0] act_div_next;
  reg [`SCD_SRC_W-1:0] act_src_reg;
  reg [`SCD_SRC_W-1:0] act_src_next;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg clk_out_next;
  reg [`SCD_DATA_W-1:0] rdata_next;

  wire ctrl_hit;
  wire ctrl_wr;
  wire int_rise;
  wire ext_rise;
  wire use_ext;
  wire sel_level;
  wire sel_rise;
  wire [CNT_W-1:0] div_mask;
  wire at_boundary;
  wire pending_differs;

  assign ctrl_hit = (reg_addr == `SCD_CTRL_ADDR);
  assign ctrl_wr = reg_wr & ctrl_hit;

  // ----------------------------------------
  // source edge detection
  // ----------------------------------------
  scd_edge u_int_edge
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .level_in(int_osc_in),
    .rise(int_rise)
  );

  scd_edge u_ext_edge
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .level_in(ext_osc_in),
    .rise(ext_rise)
  );

  // reserved source codes fall back to the internal oscillator
  assign use_ext = (act_src_reg == `SCD_SRC_EXT);
  assign sel_level = use_ext ? ext_osc_in : int_osc_in;
  assign sel_rise = use_ext ? ext_rise : int_rise;

  // ----------------------------------------
  // switch point
  // ----------------------------------------
  // new settings only take over where the divided clock has just
  // completed a period, so no runt pulse reaches the core
  assign div_mask = ~({CNT_W{1'b1}} << act_div_reg);
  assign at_boundary = sel_rise & ((cnt_reg & div_mask) == div_mask);
  assign pending_differs = (core_clock_out_divide_field_reg != act_div_reg) |
    (clock_source_select_field_reg != act_src_reg);

  // ----------------------------------------
  // control register writes
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_clock_out_divide_field_reg <= `SCD_DIV_RESET;
      clock_source_select_field_reg <= `SCD_SRC_RESET;
    end
    else if (ctrl_wr)
    begin
      core_clock_out_divide_field_reg <= reg_wdata[`SCD_DIV_MSB:`SCD_DIV_LSB];
      clock_source_select_field_reg <= reg_wdata[`SCD_SRC_MSB:`SCD_SRC_LSB];
    end
  end

  // ----------------------------------------
  // apply state machine
  // ----------------------------------------
  always @*
  begin
    state_next = state_reg;
    act_div_next = act_div_reg;
    act_src_next = act_src_reg;
    case (state_reg)
      ST_PEND:
      begin
        if (at_boundary)
        begin
          act_div_next = core_clock_out_divide_field_reg;
          act_src_next = clock_source_select_field_reg;
          // a write landing on the same edge keeps the flag low
          if (!ctrl_wr)
          begin
            state_next = ST_READY;
          end
        end
      end
      ST_READY:
      begin
        if (ctrl_wr)
        begin
          state_next = ST_PEND;
        end
      end
      default:
      begin
        state_next = ST_PEND;
      end
    endcase
  end

  // ----------------------------------------
  // divider counter and output clock
  // ----------------------------------------
  always @*
  begin
    cnt_next = cnt_reg;
    if (at_boundary && (state_reg == ST_PEND))
    begin
      cnt_next = {CNT_W{1'b0}};
    end
    else if (sel_rise)
    begin
      cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // bit k of the edge count toggles every 2**k source periods
  always @*
  begin
    if (act_div_reg == `SCD_DIV_RESET)
    begin
      clk_out_next = sel_level;
    end
    else
    begin
      clk_out_next = cnt_reg[act_div_reg - 3'h1];
    end
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_PEND;
      act_div_reg <= `SCD_DIV_RESET;
      act_src_reg <= `SCD_SRC_RESET;
      cnt_reg <= {CNT_W{1'b0}};
      core_clock_out <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      act_div_reg <= act_div_next;
      act_src_reg <= act_src_next;
      cnt_reg <= cnt_next;
      core_clock_out <= clk_out_next;
    end
  end

  // pending compare keeps the flag honest if the state and values drift
  assign divider_ready_flag = (state_reg == ST_READY) & ~pending_differs;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @*
  begin
    rdata_next = {`SCD_DATA_W{1'b0}};
    if (reg_rd && ctrl_hit)
    begin
      rdata_next[`SCD_READY_BIT] = divider_ready_flag;
      rdata_next[`SCD_DIV_MSB:`SCD_DIV_LSB] = core_clock_out_divide_field_reg;
      rdata_next[`SCD_RSVD_BIT] = 1'b0;
      rdata_next[`SCD_SRC_MSB:`SCD_SRC_LSB] = clock_source_select_field_reg;
    end
  end

  // data stands only in the cycle after the read strobe
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= {`SCD_DATA_W{1'b0}};
    end
    else
    begin
      reg_rdata <= rdata_next;
    end
  end

endmodule

`default_nettype wire

// >>> dv/scd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module scd_properties
#(
  parameter CNT_W = 7
)
(
  input wire core_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire int_osc_in,
  input wire ext_osc_in,
  input wire core_clock_out,
  input wire divider_ready_flag
);
  // ----
  // watch
  // ----
  logic [7:0] last_wr_reg;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      last_wr_reg <= 8'h00;
    else if (reg_wr && reg_addr == 8'hbd)
      last_wr_reg <= reg_wdata;
  end
  sequence ctrl_rd;
    reg_rd && reg_addr == 8'hbd;
  endsequence
  sequence ctrl_wr;
    reg_wr && reg_addr == 8'hbd;
  endsequence
  // second ready cycle: the first still shows the old path
  sequence held(code);
    divider_ready_flag && last_wr_reg[6:0] == code ##1 divider_ready_flag;
  endsequence
  chk_rsvd_reads_zero: assert property (reg_rdata[3] == 1'b0)
    else $error("reserved bit set");
  chk_read_ready: assert property (ctrl_rd |=> reg_rdata[7] == $past(divider_ready_flag))
    else $error("ready bit mismatch");
  chk_write_drops: assert property (ctrl_wr |=> !divider_ready_flag)
    else $error("ready kept after write");
  chk_ext_passes: assert property (held(7'h01) |-> core_clock_out == $past(ext_osc_in))
    else $error("external source not passed");
  chk_int_passes: assert property (held(7'h00) |-> core_clock_out == $past(int_osc_in))
    else $error("internal source not passed");
  chk_reset_clear: assert property ($rose(resetn) |-> reg_rdata == 8'h00 && !divider_ready_flag)
    else $error("not clear after reset");
endmodule
bind scd_clock_ctrl scd_properties #(.CNT_W(CNT_W)) chk_u (.core_clk(core_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .int_osc_in(int_osc_in), .ext_osc_in(ext_osc_in),
  .core_clock_out(core_clock_out), .divider_ready_flag(divider_ready_flag));
`default_nettype wire

// >>> dv/test_system_clock_select_divider.sv
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_select_divider;
  logic core_clk, resetn, reg_wr, reg_rd;
  // oscillators start low so the edge detectors see no false rise
  logic int_osc_in = 1'b0;
  logic ext_osc_in = 1'b0;
  logic [7:0] reg_addr, reg_wdata, v;
  logic [1:0] e = 2'h0;
  wire [7:0] reg_rdata;
  wire core_clock_out, divider_ready_flag;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  scd_clock_ctrl dut_u (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .int_osc_in(int_osc_in), .ext_osc_in(ext_osc_in), .core_clock_out(core_clock_out),
    .divider_ready_flag(divider_ready_flag));
  // ----
  // stimulus
  // ----
  initial
  begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  // internal source period 2 cycles, external 6
  always @(posedge core_clk)
  begin
    int_osc_in <= ~int_osc_in;
    e <= (e == 2'h2) ? 2'h0 : e + 2'h1;
    if (e == 2'h2)
      ext_osc_in <= ~ext_osc_in;
  end
  task chk(input string s, input [15:0] g, input [15:0] x);
    checks_done++;
    if (g !== x)
    begin
      bad_count++;
      $display("FAIL %s exp %h got %h", s, x, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
    #1;
  endtask
  task rd(input [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  task rdy;
    for (int i = 0; i < 2000 && divider_ready_flag !== 1'b1; i++)
      @(posedge core_clk) #1;
  endtask
  task per;
    n = 0;
    while (core_clock_out !== 1'b0) @(posedge core_clk) #1;
    while (core_clock_out !== 1'b1) @(posedge core_clk) #1;
    while (core_clock_out === 1'b1)
    begin
      @(posedge core_clk) #1;
      n++;
    end
    while (core_clock_out === 1'b0)
    begin
      @(posedge core_clk) #1;
      n++;
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #40000;
    bad_count++;
    conclude;
  end
  initial
  begin
    resetn = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (12) @(posedge core_clk);
    resetn <= 1;
    rd(8'hbd);
    chk("reset", {8'h00, v & 8'h7f}, 16'h0000);
    for (int k = 0; k < 8; k++)
    begin
      wr(8'hbd, {1'b0, k[2:0], 4'h0});
      rdy;
      rd(8'hbd);
      chk("ctrl", {8'h00, v}, {8'h00, 1'b1, k[2:0], 4'h0});
      per;
      chk("period", n[15:0], 16'(2 << k));
    end
    // reserved codes fall back to internal; read-only bit 7 ignores writes
    wr(8'hbd, 8'h01);
    rdy;
    per;
    chk("ext period", n[15:0], 16'h0006);
    wr(8'hbd, 8'h02);
    rdy;
    rd(8'hbd);
    chk("rsvd code", {8'h00, v}, 16'h0082);
    wr(8'hbd, 8'h87);
    rdy;
    rd(8'hbd);
    chk("ro bits", {8'h00, v}, 16'h0087);
    per;
    chk("fallback", n[15:0], 16'h0002);
    wr(8'hbc, 8'h70);
    rd(8'hbc);
    chk("unmapped", {8'h00, v}, 16'h0000);
    rd(8'hbd);
    chk("kept", {8'h00, v}, 16'h0087);
    conclude;
  end
endmodule
`default_nettype wire
